// ### verilog/bus_master_cycles.sv
// Contract
// - Byte access: bit zero picks single lane.
// - Word read asserts both byte strobes.
// - State 0: address floats, code driven, read.
// - State 1: address driven, space code valid.
// - State 2: address strobe; read strobes too.
// - No acknowledge by state 5: wait states.
// - Read data latched entering state 7.
// - State 7 negates strobes (address strobe stays asserted in read-modify-write), holds address, direction.
// - Tolerate acknowledge lingering into next cycle.
// - Write: direction low state 2, data 3.
// - Write strobes asserted in state 4.
// - Write holds data through 7, then releases.
// - Address strobe unbroken across read-modify-write.
// - Read-modify-write only for single-byte test-and-set.
// - Write phase: states 12 through 19.
// - Write phase negates strobes in state 19.
// - Space code valid while address strobe asserted.
module bus_master_cycles
	import bus_cycle_pkg::*;
(
	input wire logic SYS_CLK, // System clock, 100 MHz.
	input wire logic RST_N, // Asynchronous reset, active low.
	input wire logic REQ_VALID, // Cycle request offered.
	output logic REQ_READY, // Request taken when both high.
	input wire logic [1:0] REQ_OP, // Read, write or test-and-set.
	input wire logic REQ_WORD, // Word access when high, except test-and-set, which is always a byte access.
	input wire logic [ADDR_W:0] REQ_ADDR, // Byte address.
	input wire logic [FC_W-1:0] REQ_SPACE, // Space code for the cycle.
	input wire logic [DATA_W-1:0] REQ_WDATA, // Write data.
	output logic RD_VALID, // Read result available.
	input wire logic RD_READY, // Read result taken.
	output logic [DATA_W-1:0] RD_DATA, // Read result.
	output logic BUSY, // Bus cycle in progress.
	output logic [ADDR_W-1:0] WORD_ADDRESS_BUS, // Word address out.
	output logic WORD_ADDRESS_OE, // Address bus driven.
	input wire logic [DATA_W-1:0] DATA_BUS_16_IN, // Data bus in.
	output logic [DATA_W-1:0] DATA_BUS_16_OUT, // Data bus out.
	output logic DATA_BUS_16_OE, // Data bus driven.
	output logic READ_NOT_WRITE, // High read, low write.
	output logic ADDR_VALID_STROBE_N, // Address strobe.
	output logic UPPER_BYTE_STROBE_N, // Upper byte strobe.
	output logic LOWER_BYTE_STROBE_N, // Lower byte strobe.
	output logic [FC_W-1:0] SPACE_CODE, // Space code out.
	input wire logic XFER_ACK_N // Slave acknowledge.
);

	// ----------------------------------------------------------------
	// Reset release and input synchronisers
	// ----------------------------------------------------------------
	logic rst_m_q, rst_n_q;
	logic ack_m_q, ack_n_s_q;
	logic [DATA_W-1:0] din_m_q, din_s_q;

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ack_m_q <= 1'b1;
			ack_n_s_q <= 1'b1;
			din_m_q <= DATA_RST;
			din_s_q <= DATA_RST;
		end else begin
			ack_m_q <= XFER_ACK_N;
			ack_n_s_q <= ack_m_q;
			din_m_q <= DATA_BUS_16_IN;
			din_s_q <= din_m_q;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [ST_W-1:0] base_st(input logic [ST_W-1:0] s);
		return (s >= RMW_OFS) ? s - RMW_OFS : s;
	endfunction

	function automatic logic in_st(input logic [ST_W-1:0] s, lo, hi);
		return s >= lo && s <= hi;
	endfunction

	// ----------------------------------------------------------------
	// Request latch and state divider
	// ----------------------------------------------------------------
	phase_t phase_q, phase_d;
	op_t op_q;
	logic [ST_W-1:0] st_q, st_d;
	logic [DIV_W-1:0] div_q;
	logic word_q, req_ready_q, accept, tick;
	logic [ADDR_W:0] addr_q;
	logic [FC_W-1:0] fc_q;

	assign accept = REQ_VALID && req_ready_q;
	// one numbered state every STATE_CYC system clocks.
	assign tick = div_q == STATE_CYC - 1'b1;

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_q <= '0;
		end else if (accept || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			op_q <= OP_READ;
			word_q <= 1'b0;
			addr_q <= ADDR_RST;
			fc_q <= FC_RST;
		end else if (accept) begin
			op_q <= op_t'(REQ_OP);
			word_q <= REQ_WORD && op_t'(REQ_OP) != OP_TAS;
			addr_q <= REQ_ADDR;
			fc_q <= REQ_SPACE;
		end
	end

	// ----------------------------------------------------------------
	// Bus state sequence
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		phase_d = phase_q;
		case (phase_q)
			PH_IDLE: begin
				if (accept) begin
					st_d = FIRST_BUS_STATE;
					phase_d = PH_RUN;
				end
			end
			PH_RUN: begin
				if (tick) begin
					if (st_q == (op_q == OP_TAS ? S_RMW_END : S_END)) begin
						phase_d = PH_IDLE;
					end else if (base_st(st_q) == S_WSTROBE && ack_n_s_q) begin
						phase_d = PH_WAIT;
					end else begin
						st_d = st_q + 1'b1;
					end
				end
			end
			PH_WAIT: begin
				if (tick && !ack_n_s_q) begin
					st_d = st_q + 1'b1;
					phase_d = PH_RUN;
				end
			end
			default: phase_d = PH_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			phase_q <= PH_IDLE;
			st_q <= FIRST_BUS_STATE;
		end else begin
			phase_q <= phase_d;
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Pin decode from the next state
	// ----------------------------------------------------------------
	logic busy_d, wrp_d, rdp_d, as_on, ds_on, up_on, lo_on;
	logic [ST_W-1:0] b_d;

	assign busy_d = phase_d != PH_IDLE;
	assign b_d = base_st(st_d);
	assign wrp_d = busy_d && (op_q == OP_WRITE || (op_q == OP_TAS && st_d >= RMW_OFS + S_STROBE));
	assign rdp_d = busy_d && op_q != OP_WRITE && st_d <= S_END;
	assign as_on = busy_d && in_st(st_d, S_STROBE,
		op_q == OP_TAS ? S_RMW_END - 1'b1 : S_LAST_DS);
	assign ds_on = (rdp_d && in_st(b_d, S_STROBE, S_LAST_DS)) ||
		(wrp_d && in_st(b_d, S_WSTROBE, S_LAST_DS));
	assign up_on = ds_on && (word_q || !addr_q[0]);
	assign lo_on = ds_on && (word_q || addr_q[0]);

	logic as_n_q, uds_n_q, lds_n_q, rw_q, aoe_q, doe_q;

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			as_n_q <= 1'b1;
			uds_n_q <= 1'b1;
			lds_n_q <= 1'b1;
			rw_q <= 1'b1;
			aoe_q <= 1'b0;
			doe_q <= 1'b0;
		end else begin
			// strobes drop in the last state.
			as_n_q <= !as_on;
			uds_n_q <= !up_on;
			lds_n_q <= !lo_on;
			// state 0 reads with address floating.
			rw_q <= !(wrp_d && b_d >= S_STROBE);
			aoe_q <= busy_d && st_d >= S_ADDR;
			// data driven 3 to 7, then released.
			doe_q <= wrp_d && b_d >= S_WDATA;
		end
	end

	// ----------------------------------------------------------------
	// Data path: write data, capture, modify
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] dout_q, rd_hold_q, din_sel;
	logic [7:0] tas_byte;
	logic cap, push_q, fifo_in_ready;

	assign din_sel = word_q ? din_s_q :
		{8'h00, addr_q[0] ? din_s_q[7:0] : din_s_q[15:8]};
	assign tas_byte = rd_hold_q[7:0] | TAS_SET_MASK;
	// latch at the start of state 7.
	assign cap = op_q != OP_WRITE && phase_q != PH_IDLE && st_q != S_END && st_d == S_END;

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dout_q <= DATA_RST;
		end else if (accept) begin
			dout_q <= REQ_WORD ? REQ_WDATA : {2{REQ_WDATA[7:0]}};
		end else if (op_q == OP_TAS && st_q != S_MOD_END && st_d == S_MOD_END) begin
			dout_q <= {2{tas_byte}};
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rd_hold_q <= DATA_RST;
			push_q <= 1'b0;
		end else begin
			push_q <= cap;
			if (cap) begin
				rd_hold_q <= din_sel;
			end
		end
	end

	// A request is only taken while the result queue has room, so a
	// captured read can never be dropped; a slow reader stalls the bus.
	always_ff @(posedge SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			req_ready_q <= 1'b0;
			BUSY <= 1'b0;
		end else begin
			req_ready_q <= !busy_d && !push_q && fifo_in_ready && !accept;
			BUSY <= busy_d;
		end
	end

	word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
		.clk(SYS_CLK),
		.rst_n(rst_n_q),
		.in_valid(push_q),
		.in_ready(fifo_in_ready),
		.in_data(rd_hold_q),
		.out_valid(RD_VALID),
		.out_ready(RD_READY),
		.out_data(RD_DATA)
	);

	assign REQ_READY = req_ready_q;
	assign WORD_ADDRESS_BUS = addr_q[ADDR_W:1];
	assign WORD_ADDRESS_OE = aoe_q;
	assign DATA_BUS_16_OUT = dout_q;
	assign DATA_BUS_16_OE = doe_q;
	assign READ_NOT_WRITE = rw_q;
	assign ADDR_VALID_STROBE_N = as_n_q;
	assign UPPER_BYTE_STROBE_N = uds_n_q;
	assign LOWER_BYTE_STROBE_N = lds_n_q;
	// code held from request to end.
	assign SPACE_CODE = fc_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!rst_n_q);

	chk_byte_lane: assert property (!word_q && !(uds_n_q && lds_n_q) |->
		(uds_n_q == addr_q[0]) && (lds_n_q != addr_q[0])) else $error("byte lane wrong");
	chk_word_lanes: assert property (word_q && phase_q != PH_IDLE &&
		st_q == S_LAST_DS |-> !uds_n_q && !lds_n_q) else $error("word lanes wrong");
	chk_first_float: assert property (phase_q == PH_RUN && st_q == FIRST_BUS_STATE
		|-> !aoe_q && rw_q && as_n_q) else $error("state 0 pins wrong");
	chk_addr_valid: assert property (!as_n_q |-> aoe_q && $stable(fc_q))
		else $error("strobe without address");
	chk_ack_wait: assert property (phase_q == PH_RUN && base_st(st_q) == S_WSTROBE
		&& tick && ack_n_s_q |=> phase_q == PH_WAIT && $stable(st_q) [*2])
		else $error("wait state not taken");
	chk_read_latch: assert property (cap |=> rd_hold_q == $past(din_sel) && push_q)
		else $error("read data not latched");
	chk_end_release: assert property (phase_q == PH_RUN && st_q == S_END && op_q != OP_TAS
		|-> as_n_q && uds_n_q && lds_n_q && aoe_q) else $error("state 7 pins wrong");
	chk_write_dir: assert property (op_q == OP_WRITE && phase_q != PH_IDLE &&
		st_q == S_STROBE |-> !rw_q && !doe_q ##[1:4] doe_q) else $error("write turn wrong");
	chk_rmw_strobe: assert property (op_q == OP_TAS && phase_q != PH_IDLE &&
		in_st(st_q, S_STROBE, S_RMW_END - 1'b1) |-> !as_n_q) else $error("strobe broken");
	chk_rmw_write: assert property (op_q == OP_TAS && phase_q != PH_IDLE &&
		st_q == RMW_OFS + S_STROBE |-> !rw_q && !doe_q && uds_n_q && lds_n_q)
		else $error("rmw write phase wrong");

endmodule // bus_master_cycles

// ### verilog/bus_cycle_pkg.sv
package bus_cycle_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	localparam int FC_W = 3;
	localparam int ST_W = 5;
	localparam int DIV_W = 2;
	localparam int FIFO_DEPTH = 8;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	// One numbered bus state lasts half a processor clock.
	localparam int HALF_STATE_NS = 20;
	localparam int STATE_CYC_I = (HALF_STATE_NS / CLK_PERIOD_NS < 1) ? 1 :
		HALF_STATE_NS / CLK_PERIOD_NS;
	localparam logic [DIV_W-1:0] STATE_CYC = DIV_W'(STATE_CYC_I);

	// ----------------------------------------------------------------
	// Numbered bus states
	// ----------------------------------------------------------------
	localparam logic [ST_W-1:0] FIRST_BUS_STATE = 5'd0;
	localparam logic [ST_W-1:0] S_ADDR = 5'd1;
	localparam logic [ST_W-1:0] S_STROBE = 5'd2;
	localparam logic [ST_W-1:0] S_WDATA = 5'd3;
	localparam logic [ST_W-1:0] S_WSTROBE = 5'd4;
	localparam logic [ST_W-1:0] S_LAST_DS = 5'd6;
	localparam logic [ST_W-1:0] S_END = 5'd7;
	localparam logic [ST_W-1:0] S_MOD_END = 5'd11;
	localparam logic [ST_W-1:0] RMW_OFS = 5'd12;
	localparam logic [ST_W-1:0] S_RMW_END = 5'd19;

	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [FC_W-1:0] FC_RST = 3'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [ADDR_W:0] ADDR_RST = 24'h000000;
	localparam logic [7:0] TAS_SET_MASK = 8'h80;

	typedef enum logic [1:0] {
		OP_READ = 2'b00,
		OP_WRITE = 2'b01,
		OP_TAS = 2'b10
	} op_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_RUN = 2'b01,
		PH_WAIT = 2'b11
	} phase_t;

endpackage

// ### verilog/word_fifo.sv
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk, // Clock.
	input wire logic rst_n, // Synchronised reset, active low.
	input wire logic in_valid, // Word offered.
	output logic in_ready, // Room for a word.
	input wire logic [WIDTH-1:0] in_data, // Word in.
	output logic out_valid, // Word available.
	input wire logic out_ready, // Consumer takes word.
	output logic [WIDTH-1:0] out_data // Oldest word.
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q, rd_q;
	logic [PW:0] cnt_q;
	logic push, pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = cnt_q != (PW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rd_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

endmodule // word_fifo

// ### tb/bus_slave_model.sv
module bus_slave_model
	import bus_cycle_pkg::*;
(
	input wire logic clk, // Clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic [ADDR_W-1:0] addr, // Word address.
	input wire logic as_n, // Address strobe.
	input wire logic uds_n, // Upper byte strobe.
	input wire logic lds_n, // Lower byte strobe.
	input wire logic rnw, // High read, low write.
	input wire logic [DATA_W-1:0] bus_in, // Data from the master.
	input wire logic [3:0] delay, // Cycles before answering.
	output logic [DATA_W-1:0] dout, // Data to the master.
	output logic doe, // Data driven.
	output logic ack_n // Acknowledge, active low.
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [DATA_W-1:0] mem [0:15];
	logic [3:0] cnt_q;
	logic sel;
	int i;

	assign sel = !as_n && !(uds_n && lds_n);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < 16; i++) begin
				mem[i] <= 16'h0000;
			end
			cnt_q <= 4'h0;
			doe <= 1'b0;
			ack_n <= 1'b1;
			dout <= 16'h5a5a;
		end else if (!sel) begin
			// release within one clock
			// An idle bus toggles so a stale value can never pass for a read.
			cnt_q <= 4'h0;
			ack_n <= 1'b1;
			doe <= 1'b0;
			dout <= ~dout;
		end else if (cnt_q < delay) begin
			cnt_q <= cnt_q + 4'h1;
		end else if (ack_n) begin
			ack_n <= 1'b0;
			if (rnw) begin
				doe <= 1'b1;
				dout <= mem[addr[3:0]];
			end else begin
				if (!uds_n) begin
					mem[addr[3:0]][15:8] <= bus_in[15:8];
				end
				if (!lds_n) begin
					mem[addr[3:0]][7:0] <= bus_in[7:0];
				end
			end
		end
	end
endmodule // bus_slave_model

// ### tb/async_bus_master_cycles_tb_top.sv
module async_bus_master_cycles_tb_top;
	import bus_cycle_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic [1:0] req_op = OP_READ;
	logic req_word = 1'b0;
	logic [ADDR_W:0] req_addr = '0;
	logic [FC_W-1:0] req_space = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic rd_ready = 1'b0;
	logic [3:0] delay = 4'h0;
	logic req_ready, rd_valid, busy, wa_oe, doe, rnw, as_n, uds_n, lds_n, ack_n, s_doe;
	logic [DATA_W-1:0] rd_data, dout, s_dout, bus;
	logic [ADDR_W-1:0] wab;
	logic [FC_W-1:0] space;
	logic u, l;
	int failures = 0;
	int tests_run = 0;
	int as_run = 0;
	int n;

	always #5 sys_clk = ~sys_clk;
	assign bus = doe ? dout : s_dout;
	always @(negedge sys_clk) if (as_n === 1'b0) as_run++;

	bus_master_cycles DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .REQ_OP(req_op), .REQ_WORD(req_word), .REQ_ADDR(req_addr),
		.REQ_SPACE(req_space), .REQ_WDATA(req_wdata), .RD_VALID(rd_valid),
		.RD_READY(rd_ready), .RD_DATA(rd_data), .BUSY(busy), .WORD_ADDRESS_BUS(wab),
		.WORD_ADDRESS_OE(wa_oe), .DATA_BUS_16_IN(bus), .DATA_BUS_16_OUT(dout),
		.DATA_BUS_16_OE(doe), .READ_NOT_WRITE(rnw), .ADDR_VALID_STROBE_N(as_n),
		.UPPER_BYTE_STROBE_N(uds_n), .LOWER_BYTE_STROBE_N(lds_n), .SPACE_CODE(space),
		.XFER_ACK_N(ack_n));

	bus_slave_model slave (.clk(sys_clk), .rst_n(rst_n), .addr(wab), .as_n(as_n),
		.uds_n(uds_n), .lds_n(lds_n), .rnw(rnw), .bus_in(bus), .delay(delay),
		.dout(s_dout), .doe(s_doe), .ack_n(ack_n));

	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			failures++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	task automatic summarize();
		if (failures == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// One bus cycle through the request port
	// ----------------------------------------------------------------
	task automatic cyc(input logic [1:0] op, input logic word, input logic [ADDR_W:0] a,
		input logic [FC_W-1:0] sp, input logic [DATA_W-1:0] wd);
		int k;
		k = 0;
		while (req_ready !== 1'b1 && k < 100) begin
			@(negedge sys_clk);
			k++;
		end
		req_valid = 1'b1;
		req_op = op;
		req_word = word;
		req_addr = a;
		req_space = sp;
		req_wdata = wd;
		as_run = 0;
		@(negedge sys_clk);
		req_valid = 1'b0;
		k = 0;
		while (as_n !== 1'b0 && k < 50) begin
			@(negedge sys_clk);
			k++;
		end
		check(space === sp, "space code");
		check(wa_oe === 1'b1 && wab === a[ADDR_W:1], "address out");
		check(rnw === (op != OP_WRITE), "direction at strobe");
		if (op == OP_WRITE) begin
			check(doe === 1'b0 && uds_n === 1'b1 && lds_n === 1'b1, "write early");
			while (uds_n === 1'b1 && lds_n === 1'b1 && k < 100) begin
				@(negedge sys_clk);
				k++;
			end
			check(doe === 1'b1 && s_doe === 1'b0 && dout === (word ? wd : {wd[7:0], wd[7:0]}),
				"wdata");
		end
		u = uds_n;
		l = lds_n;
		k = 0;
		while (busy !== 1'b0 && k < 200) begin
			@(negedge sys_clk);
			k++;
		end
		check(wa_oe === 1'b0 && doe === 1'b0 && rnw === 1'b1, "release");
		n = as_run;
	endtask

	task automatic get_rd(input logic [DATA_W-1:0] exp);
		int k;
		k = 0;
		while (rd_valid !== 1'b1 && k < 100) begin
			@(negedge sys_clk);
			k++;
		end
		check(rd_data === exp, "read data");
		rd_ready = 1'b1;
		@(negedge sys_clk);
		rd_ready = 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_word();
		// A write acknowledge can only follow the strobes of state 4, so the two
		// synchroniser stages always cost one wait state with this slave.
		cyc(OP_WRITE, 1'b1, 24'h000010, 3'h1, 16'h1234);
		check(u === 1'b0 && l === 1'b0 && n == 6 * STATE_CYC, "word write");
		cyc(OP_READ, 1'b1, 24'h000010, 3'h2, 16'h0000);
		check(u === 1'b0 && l === 1'b0 && n == 5 * STATE_CYC, "word read");
		get_rd(16'h1234);
	endtask

	task automatic t_byte();
		cyc(OP_WRITE, 1'b0, 24'h000021, 3'h5, 16'h00ab);
		check(u === 1'b1 && l === 1'b0, "odd byte lane");
		cyc(OP_WRITE, 1'b0, 24'h000020, 3'h6, 16'h00cd);
		check(u === 1'b0 && l === 1'b1, "even byte lane");
		cyc(OP_READ, 1'b1, 24'h000020, 3'h1, 16'h0000);
		get_rd(16'hcdab);
		cyc(OP_READ, 1'b0, 24'h000021, 3'h2, 16'h0000);
		check(u === 1'b1 && l === 1'b0, "byte read lane");
		get_rd(16'h00ab);
	endtask

	task automatic t_wait();
		delay = 4'h7;
		cyc(OP_READ, 1'b1, 24'h000020, 3'h5, 16'h0000);
		check(n > 5 * STATE_CYC && n % STATE_CYC == 0, "wait states");
		get_rd(16'hcdab);
		delay = 4'h0;
	endtask

	task automatic t_tas();
		// Kept off the word that the queue test reads back.
		cyc(OP_WRITE, 1'b0, 24'h000033, 3'h1, 16'h0012);
		cyc(OP_TAS, 1'b1, 24'h000033, 3'h5, 16'h0000);
		check(n == 18 * STATE_CYC, "strobe unbroken");
		check(u === 1'b1 && l === 1'b0, "single lane");
		get_rd(16'h0012);
		cyc(OP_READ, 1'b0, 24'h000033, 3'h1, 16'h0000);
		get_rd({8'h00, 8'h12 | TAS_SET_MASK});
	endtask

	task automatic t_fifo();
		int k;
		for (k = 0; k < FIFO_DEPTH; k++) begin
			cyc(OP_READ, 1'b1, 24'h000010, 3'h2, 16'h0000);
		end
		for (k = 0; k < 30; k++) begin
			@(negedge sys_clk);
			check(req_ready === 1'b0 && as_n === 1'b1, "full refusal");
		end
		for (k = 0; k < FIFO_DEPTH; k++) begin
			get_rd(16'h1234);
		end
		check(rd_valid === 1'b0, "drained");
	endtask

	initial begin
		#200us;
		failures++;
		summarize();
	end

	initial begin
		repeat (2) @(negedge sys_clk);
		check(as_n === 1'b1 && uds_n === 1'b1 && lds_n === 1'b1, "reset strobes");
		check(wa_oe === 1'b0 && doe === 1'b0 && req_ready === 1'b0, "reset enables");
		@(negedge sys_clk);
		rst_n = 1'b1;
		t_word();
		t_byte();
		t_wait();
		t_tas();
		t_fifo();
		summarize();
	end
endmodule // async_bus_master_cycles_tb_top
